// ==== sim/epp_dev_model.sv ====
`default_nettype none
module epp_dev_model
  import epp_pkg::*;
(
  input wire logic chip_select_n,
  input wire logic output_strobe_n,
  input wire logic write_pulse_n,
  input wire logic test_mode_select,
  input wire logic [ADDR_W-1:0] byte_address_lines,
  input wire logic [DATA_W-1:0] byte_lines,
  output logic [DATA_W-1:0] dev_q,
  output logic dev_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic code_protect_flag = 1'b1;
  wire rd = !chip_select_n && !output_strobe_n && write_pulse_n;
  wire pv = rd && test_mode_select && !byte_address_lines[6];
  initial for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = 8'hff;
  ////////////////////////////////////////
  // eprom cells only ever lose ones
  always @(negedge write_pulse_n) begin
    if (!chip_select_n && output_strobe_n && !test_mode_select)
      mem[byte_address_lines] = mem[byte_address_lines] & byte_lines;
  end
  always @(negedge byte_lines[7]) begin
    if (chip_select_n && output_strobe_n && write_pulse_n && test_mode_select
        && byte_address_lines[4])
      code_protect_flag = 1'b0;
  end
  assign dev_oe = pv || (rd && !test_mode_select && code_protect_flag);
  assign dev_q = pv ? {code_protect_flag, 7'h7f} : mem[byte_address_lines];
endmodule : epp_dev_model
`default_nettype wire

// ==== sim/test_eprom_program_protect_port.sv ====
`default_nettype none
module test_eprom_program_protect_port;
  import epp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [ADDR_W-1:0] cmd_addr = 13'h0000;
  logic [DATA_W-1:0] cmd_data = 8'h00;
  logic cmd_ready, rsp_valid, rsp_protected, cs_n, st_n, wp_n, tms, dev_oe;
  logic [ADDR_W-1:0] adr;
  logic [DATA_W-1:0] rsp_data, bo, boe, bus, dev_q, last_q;
  int fails = 0;
  int checks = 0;
  int oe_cycles = 0;
  always @(posedge clk) if (dev_oe) oe_cycles++;
  // floating lines show the inverse of their last level
  assign bus = (boe & bo) | (~boe & (dev_oe ? dev_q : ~last_q));
  always @(posedge clk) last_q <= bus;
  always #5 clk = ~clk;
  epp_host DUT (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_protected(rsp_protected), .chip_select_n(cs_n),
    .output_strobe_n(st_n), .write_pulse_n(wp_n), .test_mode_select(tms),
    .byte_address_lines(adr), .byte_lines_o(bo), .byte_lines_oe(boe), .byte_lines_i(bus));
  epp_dev_model dev (.chip_select_n(cs_n), .output_strobe_n(st_n), .write_pulse_n(wp_n),
    .test_mode_select(tms), .byte_address_lines(adr), .byte_lines(bus), .dev_q(dev_q),
    .dev_oe(dev_oe));
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task automatic cmp8(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp1
  // one op; bounded waits, a stuck handshake ends the run
  task automatic run_op(input logic [2:0] op, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      fails++;
      summarize();
    end
  endtask : run_op
  task automatic t_erased();
    run_op(OP_READ, 13'h1abc, 8'h00);
    cmp8(rsp_data, 8'hff);
    cmp1(cmd_ready, 1'b1);
    cmp1(cs_n & st_n & wp_n, 1'b1);
    cmp8(boe, 8'h00);
    run_op(OP_PROT_VERIFY, 13'h0040, 8'h00);
    cmp1(rsp_data[7], 1'b1);
    cmp1(rsp_protected, 1'b0);
  endtask : t_erased
  task automatic t_program();
    run_op(OP_PROGRAM, 13'h0123, 8'ha5);
    run_op(OP_VERIFY, 13'h0123, 8'h00);
    cmp8(rsp_data, 8'ha5);
    run_op(OP_PROGRAM, 13'h1fff, 8'h3c);
    run_op(OP_READ, 13'h1fff, 8'h00);
    cmp8(rsp_data, 8'h3c);
    run_op(OP_READ, 13'h0fff, 8'h00);
    cmp8(rsp_data, 8'hff);
    run_op(OP_READ, 13'h0123, 8'h00);
    cmp8(rsp_data, 8'ha5);
  endtask : t_program
  task automatic t_protect();
    int n0;
    run_op(OP_PROTECT, 13'h0000, 8'h00);
    run_op(OP_PROT_VERIFY, 13'h1fff, 8'h00);
    cmp1(rsp_data[7], 1'b0);
    cmp1(rsp_protected, 1'b1);
    n0 = oe_cycles;
    run_op(OP_READ, 13'h0123, 8'h00);
    cmp8(8'(oe_cycles - n0), 8'h00);
  endtask : t_protect
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_erased();
    t_program();
    t_protect();
    summarize();
  end
endmodule : test_eprom_program_protect_port
`default_nettype wire

// ==== src/epp_host.sv ====
// Functional notes
// - verify: chip select and output strobe low, write pulse high; device drives byte
// - read holds chip select low and pulses output strobe low
// - output disable holds output strobe and write pulse high
// - protect: all strobes high, test mode high, address bit four high, pulse bit seven
// - protect verify: select and strobe low, write high, test mode high, address bit six low
// - run protect verify after each protect operation
`default_nettype none
module epp_host
  import epp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [epp_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [epp_pkg::DATA_W-1:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [epp_pkg::DATA_W-1:0] rsp_data,
  output logic rsp_protected,
  output logic chip_select_n,
  output logic output_strobe_n,
  output logic write_pulse_n,
  output logic test_mode_select,
  output logic [epp_pkg::ADDR_W-1:0] byte_address_lines,
  output logic [epp_pkg::DATA_W-1:0] byte_lines_o,
  output logic [epp_pkg::DATA_W-1:0] byte_lines_oe,
  input wire logic [epp_pkg::DATA_W-1:0] byte_lines_i
);
  import epp_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  epp_state_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [2:0] op_q;
  logic [DATA_W-1:0] sync1_q, sync2_q;
  logic [DATA_W-1:0] wdata_q;
  wire cnt_zero = (cnt_q == '0);
  wire is_prog = (op_q == OP_PROGRAM);
  wire is_prot = (op_q == OP_PROTECT);
  wire is_pv = (op_q == OP_PROT_VERIFY);
  wire is_rd = (op_q == OP_READ) || (op_q == OP_VERIFY);
  ////////////////////////////////////////////////////////////////////////////////
  // op decode shared by the pin drivers
  function automatic logic op_raises_test(input logic [2:0] op);
    op_raises_test = (op == OP_PROTECT) || (op == OP_PROT_VERIFY);
  endfunction : op_raises_test
  // only program and protect ever own the byte lines
  function automatic logic op_drives_bus(input logic [2:0] op);
    op_drives_bus = (op == OP_PROGRAM) || (op == OP_PROTECT);
  endfunction : op_drives_bus
  // program strobes the write line, protect strobes byte line seven
  wire pulse_phase = (state_q == EPP_PULSE);
  // flag low means protected; erased reads one
  wire prot_now = ~sync2_q[PROT_FLAG_BIT];
  always_comb begin
    state_d = state_q;
    case (state_q)
      EPP_IDLE: if (cmd_valid) state_d = EPP_SETUP;
      EPP_SETUP: if (cnt_zero) state_d = EPP_PULSE;
      EPP_PULSE: if (cnt_zero) state_d = EPP_HOLD;
      EPP_HOLD: if (cnt_zero) state_d = EPP_DONE;
      EPP_DONE: state_d = EPP_IDLE;
      default: state_d = EPP_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    sync1_q <= byte_lines_i;
    sync2_q <= sync1_q;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= EPP_IDLE;
      cnt_q <= '0;
      op_q <= OP_READ;
      wdata_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == EPP_IDLE && cmd_valid) begin
        op_q <= cmd_op;
        wdata_q <= cmd_data;
        cnt_q <= CNT_W'(SETUP_CYC - 1);
      end else if (state_q == EPP_SETUP && cnt_zero) begin
        cnt_q <= is_rd || is_pv ? CNT_W'(SAMPLE_CYC - 1) : CNT_W'(PULSE_CYC - 1);
      end else if (state_q == EPP_PULSE && cnt_zero) begin
        cnt_q <= CNT_W'(SETUP_CYC - 1);
      end else if (!cnt_zero) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
  // pin drivers; idle is output disable with chip select high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chip_select_n <= 1'b1;
      output_strobe_n <= 1'b1;
      write_pulse_n <= 1'b1;
      test_mode_select <= 1'b0;
      byte_address_lines <= '0;
      byte_lines_o <= '1;
      byte_lines_oe <= '0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_protected <= 1'b0;
    end else begin
      cmd_ready <= (state_d == EPP_IDLE);
      rsp_valid <= (state_q == EPP_DONE);
      if (state_q == EPP_IDLE && cmd_valid) begin
        // protect ops raise test mode, others keep it low
        test_mode_select <= op_raises_test(cmd_op);
        chip_select_n <= (cmd_op == OP_PROTECT);
        byte_address_lines <= cmd_op == OP_PROTECT ? PROT_ADDR
            : cmd_op == OP_PROT_VERIFY ? (cmd_addr & ~13'h0040) : cmd_addr;
        byte_lines_o <= cmd_op == OP_PROTECT ? 8'hff : cmd_data;
        byte_lines_oe <= {DATA_W{op_drives_bus(cmd_op)}};
        output_strobe_n <= ~(cmd_op == OP_PROT_VERIFY);
      end else if (state_q == EPP_SETUP && cnt_zero) begin
        if (is_prog) write_pulse_n <= 1'b0;
        if (is_rd) output_strobe_n <= 1'b0;
        if (is_prot) byte_lines_o[PROT_FLAG_BIT] <= 1'b0;
      end else if (state_q == EPP_PULSE && cnt_zero) begin
        // sample the bus before releasing the strobe
        if (is_rd || is_pv) rsp_data <= sync2_q;
        if (is_pv) rsp_protected <= prot_now;
        write_pulse_n <= 1'b1;
        output_strobe_n <= is_pv ? 1'b0 : 1'b1;
        byte_lines_o <= wdata_q;
        if (is_prot) byte_lines_o[PROT_FLAG_BIT] <= 1'b1;
      end else if (state_q == EPP_DONE) begin
        chip_select_n <= 1'b1;
        output_strobe_n <= 1'b1;
        test_mode_select <= 1'b0;
        byte_lines_oe <= '0; // protected reads float, data is garbage
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_NO_PROG_INHIBITED: assert property (@(posedge clk) disable iff (!rst_n)
    !write_pulse_n |-> !chip_select_n) else $error("write pulse while deselected");
  AST_READ_STROBE: assert property (@(posedge clk) disable iff (!rst_n)
    (!output_strobe_n && !test_mode_select) |-> !chip_select_n && write_pulse_n)
    else $error("bad read levels");
  AST_PV_LEVELS: assert property (@(posedge clk) disable iff (!rst_n)
    (test_mode_select && !chip_select_n) |-> !byte_address_lines[6] && write_pulse_n)
    else $error("bad protect verify levels");
  AST_PROT_LEVELS: assert property (@(posedge clk) disable iff (!rst_n)
    (test_mode_select && chip_select_n) |-> byte_address_lines[4] && output_strobe_n
    && write_pulse_n) else $error("bad protect levels");
  AST_FLOAT_ON_READ: assert property (@(posedge clk) disable iff (!rst_n)
    !output_strobe_n |-> byte_lines_oe == '0) else $error("contention on byte lines");
  AST_RSP_AFTER_CMD: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == EPP_IDLE && cmd_valid) |-> ##[3:400] rsp_valid)
    else $error("no response");
  AST_RSP_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    rsp_valid |=> !rsp_valid) else $error("response not one cycle");
  AST_PV_RESULT: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == EPP_PULSE && cnt_zero && is_pv) |=> rsp_protected == !$past(sync2_q[7]))
    else $error("protect flag wrong");
  // parked pins between ops: output disable with the part deselected
  AST_IDLE_DISABLED: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == EPP_IDLE) |-> chip_select_n && output_strobe_n && write_pulse_n
    && !test_mode_select && byte_lines_oe == '0) else $error("idle pins not parked");
  AST_PROG_LEVELS: assert property (@(posedge clk) disable iff (!rst_n)
    !write_pulse_n |-> output_strobe_n && !test_mode_select && byte_lines_oe == '1)
    else $error("bad program levels");
  // address must not move under a running op
  AST_ADDR_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q != EPP_IDLE && $past(state_q) != EPP_IDLE) |-> $stable(byte_address_lines))
    else $error("address moved during op");
  AST_PV_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !(state_q == EPP_PULSE && cnt_zero && is_pv) |=> $stable(rsp_protected))
    else $error("protect flag changed outside protect verify");
  AST_READY_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_ready |-> state_q == EPP_IDLE) else $error("ready while busy");
  // width of the write pulse, counted since a repetition would be far too long
  logic [CNT_W-1:0] wp_low_q;
  always_ff @(posedge clk) begin
    if (!rst_n || write_pulse_n) begin
      wp_low_q <= '0;
    end else begin
      wp_low_q <= wp_low_q + 1'b1;
    end
  end
  AST_PULSE_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(write_pulse_n) |-> wp_low_q == CNT_W'(PULSE_CYC))
    else $error("write pulse width wrong");
  COV_READ: cover property (@(posedge clk) rsp_valid && op_q == OP_READ);
  COV_PROG: cover property (@(posedge clk) !write_pulse_n);
  COV_PROT: cover property (@(posedge clk) rsp_valid && op_q == OP_PROTECT);
  COV_PV: cover property (@(posedge clk) rsp_valid && rsp_protected);
  COV_VERIFY: cover property (@(posedge clk) rsp_valid && op_q == OP_VERIFY);
endmodule : epp_host
`default_nettype wire

// ==== src/epp_pkg.sv ====
`default_nettype none
package epp_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  // pin sampling and hold times, ns as printed by our own choice
  localparam int CLK_NS = 10;
  localparam int SETUP_NS = 100;
  localparam int PULSE_NS = 1000;
  localparam int SAMPLE_NS = 200;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 12;
  localparam logic [ADDR_W-1:0] PROT_ADDR = 13'h0010;
  localparam int PROT_FLAG_BIT = 7;
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_VERIFY = 3'h1;
  localparam logic [2:0] OP_PROGRAM = 3'h2;
  localparam logic [2:0] OP_PROTECT = 3'h3;
  localparam logic [2:0] OP_PROT_VERIFY = 3'h4;
  typedef enum logic [4:0] {
    EPP_IDLE = 5'b00001,
    EPP_SETUP = 5'b00010,
    EPP_PULSE = 5'b00100,
    EPP_HOLD = 5'b01000,
    EPP_DONE = 5'b10000
  } epp_state_e;
endpackage : epp_pkg
`default_nettype wire
